/* File: phy_ctrl.sv */
/*
  phy_ctrl: control logic of a two/one port cable physical layer:
  link-side data, system clock, link power; cable drive and sense.
  assumes: pins are async to core_clk; register port on core_clk.
*/
// Local design decisions: the register addresses and strobed register access.
// Summary of operation
// - tx lines latched on system clock
// - serialise, data-strobe encode
// - tx data on b, strobe on a
// - receiver listens, decodes a/b
// - regroup received bits, deliver
// - repeat onto other active ports
// - pair a common mode sets speed
// - pair b common mode shows bias
// - power-down keeps bias detectors only
// - isolation low differentiates outputs
// - bridge field default from strap
// - write overrides bridge default
// - bridge field at self-id 18, 19
// - one-port mode disables port 1
// - power class strap default
// - contender strap default
// - suspended port passes no packets
// - all ports suspended powers down
// - transceiver disable conditions
// - bias output disable conditions
// - cable inactive when no bias
// - power-down keeps detection, pulls reset
// - interface state from status pin
// - status low: reset, then disable
// - status back reinitialises interface
// - wake-up drives link-on square wave
`timescale 1ns/1ps
module phy_ctrl
  import phy_ctrl_pkg::*;
#(
  parameter int NPORT      = 2,  // cable ports
  parameter int LINK_SIDE_CLOCK_OUT_DIV = 2,  // core cycles per system clock period
  parameter int BIT_CYC    = 1   // core cycles per high-speed bit
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // link side
  input  wire logic [7:0]        link_tx_data,
  input  wire logic              link_tx_valid,
  input  wire logic [1:0]        link_tx_speed,
  input  wire logic              link_request,
  output logic                   link_tx_ready,
  output logic      [7:0]        link_rx_data,
  output logic                   link_rx_valid,
  output logic                   link_side_clock_out,
  input  wire logic              link_power_status,
  input  wire logic              isolation_sel_n,
  input  wire logic              wake_event,
  input  wire logic              bus_reset,
  // straps and power pins
  input  wire logic              power_down_pin,
  input  wire logic              port_count_select,
  input  wire logic              bridge_default_pin,
  input  wire logic [2:0]        power_class_pins,
  input  wire logic              contender_linkon_pin_in,
  output logic                   contender_linkon_pin_out,
  output logic                   contender_linkon_pin_oen,
  output logic                   reset_pulldown,
  output logic                   cable_inactive_flag,
  output logic                   core_powered_down,
  // cable ports
  input  wire ds_pair_t [NPORT-1:0] cable_pair_in,  // a=data, b=strobe
  output ds_pair_t      [NPORT-1:0] cable_pair_out, // b=data, a=strobe
  output logic          [NPORT-1:0] cable_pair_a_oen,
  output logic          [NPORT-1:0] cable_pair_b_oen,
  input  wire logic     [NPORT-1:0] cable_connected,
  input  wire logic     [NPORT-1:0] cable_rx_active,
  input  wire logic     [NPORT-1:0] pair_a_cm_fast,  // speed signalling
  input  wire logic     [NPORT-1:0] pair_a_cm_mid,
  input  wire logic     [NPORT-1:0] pair_b_bias_seen,
  output logic          [NPORT-1:0] cable_bias_output
);

  // ==========================================================
  // input synchronisers
  localparam int SW = 10 + 7 * NPORT;  // synchronised width
  logic [SW-1:0] sync1_q;              // first stage, read by stage two
  logic [SW-1:0] sync2_q;              // usable stage
  wire  [SW-1:0] async_in = {link_power_status, isolation_sel_n,
    power_down_pin, port_count_select, bridge_default_pin,
    power_class_pins, contender_linkon_pin_in, wake_event,
    cable_pair_in, cable_connected, cable_rx_active, pair_a_cm_fast,
    pair_a_cm_mid, pair_b_bias_seen};

  // two flops before anything reads a pin of async_in
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  // unpack the synchronised bundle
  wire             lps_s    = sync2_q[SW-1];
  wire             iso_n_s  = sync2_q[SW-2];
  wire             pd_s     = sync2_q[SW-3];
  wire             two_s    = sync2_q[SW-4];
  wire             brg_s    = sync2_q[SW-5];
  wire [2:0]       pwr_s    = sync2_q[SW-6 -: 3];
  wire             cont_s   = sync2_q[SW-9];
  wire             wake_s   = sync2_q[SW-10];
  wire [2*NPORT-1:0] pair_s = sync2_q[7*NPORT-1 -: 2*NPORT];
  wire [NPORT-1:0] conn_s   = sync2_q[5*NPORT-1 -: NPORT];
  wire [NPORT-1:0] rxact_s  = sync2_q[4*NPORT-1 -: NPORT];
  wire [NPORT-1:0] cmf_s    = sync2_q[3*NPORT-1 -: NPORT];
  wire [NPORT-1:0] cmm_s    = sync2_q[2*NPORT-1 -: NPORT];
  wire [NPORT-1:0] bias_s   = sync2_q[NPORT-1:0];

  // ==========================================================
  // strap capture after reset
  logic       strap_done_q;  // straps taken
  logic       brg_sw_q;      // software has written the bridge field
  logic [1:0] brg_q;         // bridge-awareness field
  logic [2:0] pwr_q;         // power class default
  logic       cont_q;        // contender default
  logic [9:0] ctrl_q;        // control register

  // let the synchroniser fill first
  logic [1:0] strap_cnt_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      pwr_q        <= 3'h0;
      cont_q       <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h3) begin
        strap_done_q <= 1'b1;
        pwr_q        <= pwr_s;
        cont_q       <= cont_s;
      end
    end
  end

  // ==========================================================
  // register port decode
  wire wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
  wire [1:0] brg_dflt = brg_s ? BRG_COMPLIANT : BRG_NON_BRIDGE;

  // control register and bridge field ownership
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q   <= CTRL_RESET;
      brg_sw_q <= 1'b0;
      brg_q    <= BRG_NON_BRIDGE;
    end else if (wr_ctrl) begin
      ctrl_q   <= reg_wdata[9:0];
      brg_sw_q <= 1'b1;
      brg_q    <= reg_wdata[CTRL_BRG_LSB +: 2];
    end else if (!brg_sw_q && !strap_done_q) begin
      brg_q <= brg_dflt;
    end
  end

  wire             link_control_bit   = ctrl_q[CTRL_LINK_BIT];
  wire [NPORT-1:0] pdis    = ctrl_q[CTRL_PDIS_LSB +: NPORT];
  wire [NPORT-1:0] susp    = ctrl_q[CTRL_SUSP_LSB +: NPORT];
  wire [NPORT-1:0] arbdis  = ctrl_q[CTRL_ARBD_LSB +: NPORT];

  // ==========================================================
  // port enables and power
  // port 1 only in two-port mode
  wire [NPORT-1:0] used = two_s ? {NPORT{1'b1}}
                                : {{(NPORT-1){1'b0}}, 1'b1};
  wire all_susp = ((susp & used) == used);
  wire pwr_off  = pd_s || all_susp;
  // transceiver enable per port
  wire [NPORT-1:0] xcvr_en = used & conn_s & ~arbdis & ~susp
                             & {NPORT{!pwr_off}};
  wire [NPORT-1:0] bias_en = used & ~pdis & {NPORT{!pd_s}};

  // ==========================================================
  // link power status and interface state
  logic [11:0] lps_low_q;  // cycles with status low, saturating
  iface_t      if_q;       // hardware reset leaves it disabled
  iface_t      if_d;
  wire lps_active = (lps_low_q <= 12'(LPS_RESET_CYC));
  wire link_on    = lps_active && link_control_bit;

  // interface state follows the status pin only
  always_comb begin
    if_d = if_q;
    if (lps_s) begin
      if_d = IF_NORMAL;
    end else if (lps_low_q > 12'(LPS_DISABLE_CYC)) begin
      if_d = IF_DISABLED;
    end else if (lps_low_q > 12'(LPS_RESET_CYC)) begin
      if_d = (if_q == IF_DISABLED) ? IF_DISABLED : IF_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lps_low_q <= 12'h0;
      if_q      <= IF_DISABLED;
    end else begin
      if (lps_s) begin
        lps_low_q <= 12'h0;
      end else if (lps_low_q != 12'hfff) begin
        lps_low_q <= lps_low_q + 12'h1;
      end
      if_q <= if_d;
    end
  end

  wire if_norm = (if_q == IF_NORMAL);

  // ==========================================================
  // system clock divider, stops when disabled
  logic [7:0] div_q;
  logic       sclk_q;
  wire        sclk_rise = (div_q == 8'(LINK_SIDE_CLOCK_OUT_DIV / 2 - 1)) && !sclk_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_q  <= 8'h0;
      sclk_q <= 1'b0;
    end else if (if_q == IF_DISABLED || pd_s) begin
      div_q  <= 8'h0;
      sclk_q <= 1'b0;
    end else if (div_q == 8'(LINK_SIDE_CLOCK_OUT_DIV / 2 - 1)) begin
      div_q  <= 8'h0;
      sclk_q <= !sclk_q;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end

  // ==========================================================
  // transmit: latch, serialise, data-strobe encode
  logic [7:0] tx_sh_q;   // bits still to send, lsb first
  logic [3:0] tx_cnt_q;  // bits left
  logic [7:0] tx_bc_q;   // bit period counter
  logic [7:0] tx_per_q;  // core cycles per bit at the latched speed
  ds_pair_t   tx_ds_q;   // encoded line state
  logic [3:0] tx_w;
  logic [7:0] tx_p;

  // width and bit period for the requested speed
  always_comb begin
    case (speed_t'(link_tx_speed))
      SPD_LOW: begin
        tx_w = 4'h2;
        tx_p = 8'(4 * BIT_CYC);
      end
      SPD_MID: begin
        tx_w = 4'h4;
        tx_p = 8'(2 * BIT_CYC);
      end
      default: begin
        tx_w = 4'h8;
        tx_p = 8'(BIT_CYC);
      end
    endcase
  end

  wire tx_take = sclk_rise && link_tx_valid && link_request
                 && if_norm && (tx_cnt_q == 4'h0);
  wire tx_bit  = (tx_cnt_q != 4'h0) && (tx_bc_q == 8'h0);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_q  <= 8'h0;
      tx_cnt_q <= 4'h0;
      tx_bc_q  <= 8'h0;
      tx_per_q <= 8'h1;
      tx_ds_q  <= '0;
    end else if (tx_take) begin
      tx_sh_q  <= link_tx_data;
      tx_cnt_q <= tx_w;
      tx_per_q <= tx_p;
      tx_bc_q  <= 8'h0;
    end else if (tx_bit) begin
      tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
      tx_cnt_q <= tx_cnt_q - 4'h1;
      tx_bc_q  <= tx_per_q - 8'h1;
      // strobe toggles only when data repeats
      tx_ds_q.data   <= tx_sh_q[0];
      tx_ds_q.strobe <= tx_ds_q.strobe ^ (tx_sh_q[0] == tx_ds_q.data);
    end else if (tx_bc_q != 8'h0) begin
      tx_bc_q <= tx_bc_q - 8'h1;
    end
  end

  // ==========================================================
  // receive: pick port, decode, regroup
  wire [NPORT-1:0] rx_port = rxact_s & xcvr_en;
  logic [NPORT-1:0] rx_sel;
  ds_pair_t        rx_in;   // a carries data, b carries strobe
  logic            rx_fast;
  logic            rx_mid;

  // lowest receiving port wins
  always_comb begin
    rx_sel  = '0;
    rx_in   = '0;
    rx_fast = 1'b0;
    rx_mid  = 1'b0;
    for (int p = NPORT - 1; p >= 0; p--) begin
      if (rx_port[p]) begin
        rx_sel     = '0;
        rx_sel[p]  = 1'b1;
        rx_in.data   = pair_s[2*p];
        rx_in.strobe = pair_s[2*p + 1];
        rx_fast    = cmf_s[p];
        rx_mid     = cmm_s[p];
      end
    end
  end

  logic       rx_on_q;    // a packet is being received
  logic [1:0] rx_spd_q;   // speed signalled during arbitration
  ds_pair_t   rx_prev_q;  // previous line state
  logic [7:0] rx_sh_q;    // incoming bits
  logic [3:0] rx_cnt_q;   // bits collected
  logic [7:0] rx_out_q;   // group handed to the link
  logic       rx_vld_q;
  wire rx_any  = |rx_sel;
  wire rx_edge = rx_on_q && (rx_in != rx_prev_q);  // one bit per change
  wire [3:0] rx_w = (rx_spd_q == SPD_LOW) ? 4'h2 :
                    (rx_spd_q == SPD_MID) ? 4'h4 : 4'h8;
  wire [7:0] rx_nsh = {rx_in.data, rx_sh_q[7:1]};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_on_q   <= 1'b0;
      rx_spd_q  <= SPD_LOW;
      rx_prev_q <= '0;
      rx_sh_q   <= 8'h0;
      rx_cnt_q  <= 4'h0;
      rx_out_q  <= 8'h0;
      rx_vld_q  <= 1'b0;
    end else begin
      rx_on_q   <= rx_any;
      rx_prev_q <= rx_in;
      rx_vld_q  <= 1'b0;
      if (rx_any && !rx_on_q) begin
        // speed from pair a at packet start
        rx_spd_q <= rx_fast ? SPD_HIGH : (rx_mid ? SPD_MID : SPD_LOW);
        rx_cnt_q <= 4'h0;
      end else if (rx_edge) begin
        if (rx_cnt_q + 4'h1 == rx_w) begin
          // right-align the group, lsb received first
          rx_out_q <= rx_nsh >> (4'h8 - rx_w);
          rx_vld_q <= 1'b1;
          rx_cnt_q <= 4'h0;
        end else begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
        rx_sh_q <= rx_nsh;
      end
    end
  end

  // ==========================================================
  // link-side outputs, low outside normal state when isolation_sel_n is high, frozen when it is low
  logic [7:0] lk_data_q;
  logic       lk_vld_q;
  wire  [7:0] lk_raw = if_norm ? rx_out_q : 8'h0;
  wire        lk_vraw = if_norm && rx_vld_q;
  // differentiated form: transitions only, for a coupling barrier
  wire  [7:0] lk_data_d = iso_n_s ? lk_raw : (lk_raw ^ lk_data_q);
  wire        lk_vld_d  = iso_n_s ? lk_vraw : (lk_vraw ^ lk_vld_q);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lk_data_q <= 8'h0;
      lk_vld_q  <= 1'b0;
    end else begin
      lk_data_q <= lk_data_d;
      lk_vld_q  <= lk_vld_d;
    end
  end

  // ==========================================================
  // link-on square wave on wake-up while link inactive
  logic       wake_pend_q;
  logic       wake_prev_q;
  logic [7:0] lon_cnt_q;
  logic       lon_q;
  wire wake_rise = wake_s && !wake_prev_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_pend_q <= 1'b0;
      wake_prev_q <= 1'b0;
      lon_cnt_q   <= 8'h0;
      lon_q       <= 1'b0;
    end else begin
      wake_prev_q <= wake_s;
      // a new wake-up beats a bus_reset clear in the same cycle; link_on beats a wake-up
      if (wake_rise && !link_on) begin
        wake_pend_q <= 1'b1;
      end else if (link_on || bus_reset) begin
        wake_pend_q <= 1'b0;
      end
      if (!wake_pend_q) begin
        lon_cnt_q <= 8'h0;
        lon_q     <= 1'b0;
      end else if (lon_cnt_q == 8'(LINKON_HALF_CYC - 1)) begin
        lon_cnt_q <= 8'h0;
        lon_q     <= !lon_q;
      end else begin
        lon_cnt_q <= lon_cnt_q + 8'h1;
      end
    end
  end

  // ==========================================================
  // cable drive, repeat, bias and status outputs
  logic [NPORT-1:0] a_oen_d;
  logic [NPORT-1:0] b_oen_d;
  ds_pair_t [NPORT-1:0] pout_d;
  wire tx_busy = (tx_cnt_q != 4'h0);

  // receiver listens, others send or repeat
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      a_oen_d[p] = 1'b1;
      b_oen_d[p] = 1'b1;
      pout_d[p]  = '0;
      if (xcvr_en[p] && !rx_sel[p]) begin
        if (rx_any) begin
          a_oen_d[p] = 1'b0;
          b_oen_d[p] = 1'b0;
          pout_d[p]  = rx_in;
        end else if (tx_busy) begin
          a_oen_d[p] = 1'b0;
          b_oen_d[p] = 1'b0;
          pout_d[p]  = tx_ds_q;
        end
      end
    end
  end

  logic [31:0] rd_q;
  wire [31:0] sid_w = (32'(brg_q)  << SID_BRG_LSB)
                    | (32'(cont_q) << SID_CONT_BIT)
                    | (32'(pwr_q)  << SID_PWR_LSB);
  wire [31:0] stat_w = {24'h0, pd_s, all_susp, link_on, if_q,
                        ~|(bias_s & used), 2'(bias_s & used)};
  wire [31:0] rd_d = (reg_addr == CTRL_ADDR)   ? {22'h0, ctrl_q} :
                     (reg_addr == STATUS_ADDR) ? stat_w :
                     (reg_addr == SELFID_ADDR) ? sid_w : 32'h0;

  // output registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cable_pair_out      <= '0;
      cable_pair_a_oen    <= '1;
      cable_pair_b_oen    <= '1;
      cable_bias_output   <= '0;
      cable_inactive_flag <= 1'b1;
      reset_pulldown      <= 1'b0;
      core_powered_down   <= 1'b0;
      link_side_clock_out <= 1'b0;
      link_tx_ready       <= 1'b0;
      rd_q                <= 32'h0;
    end else begin
      cable_pair_out      <= pout_d;
      cable_pair_a_oen    <= a_oen_d;
      cable_pair_b_oen    <= b_oen_d;
      cable_bias_output   <= bias_en;
      cable_inactive_flag <= ~|(bias_s & used);
      reset_pulldown      <= pd_s;
      core_powered_down   <= pwr_off;
      link_side_clock_out <= sclk_q;
      link_tx_ready       <= if_norm && !tx_busy && !tx_take;
      rd_q                <= reg_rd ? rd_d : 32'h0;
    end
  end

  assign reg_rdata                = rd_q;
  assign link_rx_data             = lk_data_q;
  assign link_rx_valid            = lk_vld_q;
  assign contender_linkon_pin_out = lon_q;
  // drive only while signalling; strap input otherwise
  assign contender_linkon_pin_oen = !wake_pend_q;

endmodule

/* File: phy_ctrl_pkg.sv */
/*
  phy_ctrl_pkg: constants and types of the phy control block.
  assumes: core clock of 100 MHz.
*/
package phy_ctrl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CORE_CLK_MHZ    = 100;
  localparam int LPS_RESET_NS    = 2600;  // 2.6 us low -> interface reset
  localparam int LPS_DISABLE_NS  = 26000; // 26 us low -> interface disabled
  localparam int LINKON_PER_NS   = 163;   // wake-up square wave period
  // all times round down
  localparam int LPS_RESET_CYC   = LPS_RESET_NS * CORE_CLK_MHZ / 1000;
  localparam int LPS_DISABLE_CYC = LPS_DISABLE_NS * CORE_CLK_MHZ / 1000;
  localparam int LINKON_HALF_CYC = LINKON_PER_NS * CORE_CLK_MHZ / 2000;

  // ==========================================================
  // register map
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] SELFID_ADDR = 4'h8;

  // control fields
  localparam int CTRL_LINK_BIT  = 0;     // link control bit
  localparam int CTRL_PDIS_LSB  = 1;     // port disable by link, 2 bits
  localparam int CTRL_SUSP_LSB  = 3;     // port suspend, 2 bits
  localparam int CTRL_ARBD_LSB  = 5;     // arbitration disable, 2 bits
  localparam int CTRL_BRG_LSB   = 8;     // bridge-awareness field, 2 bits
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // self-identification field positions
  localparam int SID_PWR_LSB  = 8;      // power class, 3 bits
  localparam int SID_CONT_BIT = 11;     // bus-manager contender
  localparam int SID_BRG_LSB  = 18;     // bridge field, bits 18 and 19

  localparam logic [1:0] BRG_NON_BRIDGE = 2'h0;
  localparam logic [1:0] BRG_COMPLIANT  = 2'h3;

  // ==========================================================
  // speed classes and link interface states
  typedef enum logic [1:0] {
    SPD_LOW  = 2'h0,
    SPD_MID  = 2'h1,
    SPD_HIGH = 2'h2
  } speed_t;

  typedef enum logic [1:0] {
    IF_NORMAL   = 2'h0,
    IF_RESET    = 2'h1,
    IF_DISABLED = 2'h3
  } iface_t;

  // data-strobe pair
  typedef struct packed {
    logic strobe;
    logic data;
  } ds_pair_t;

endpackage

/* File: phy_ctrl_asserts.sv */
/* phy_ctrl_asserts: port timing checks for phy_ctrl.
   assumes: bound into every phy_ctrl; pins settle in 4 cycles. */
`timescale 1ns/1ps
module phy_ctrl_asserts
  import phy_ctrl_pkg::*;
#(
  parameter int NPORT = 2
) (
  input wire logic             core_clk,
  input wire logic             rstn,
  input wire logic             power_down_pin,
  input wire logic             port_count_select,
  input wire logic [NPORT-1:0] pair_b_bias_seen,
  input wire logic [NPORT-1:0] cable_bias_output,
  input wire logic [NPORT-1:0] cable_pair_a_oen,
  input wire logic [NPORT-1:0] cable_pair_b_oen,
  input wire logic             cable_inactive_flag,
  input wire logic             reset_pulldown,
  input wire logic             core_powered_down,
  input wire logic             link_side_clock_out,
  input wire logic             contender_linkon_pin_out,
  input wire logic             contender_linkon_pin_oen
);
  // ==========================================================
  // power-down and pin sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // 4 cycles: 2 sync flops, sclk_q, output flop
  sequence pd_held;
    power_down_pin [*4];
  endsequence
  sequence one_port;
    !port_count_select [*4];
  endsequence
  a_pd_bias_off:
    assert property (pd_held |=> cable_bias_output == '0)
    else $error("bias on in power down");
  a_pd_pulldown:
    assert property (pd_held |=> reset_pulldown && core_powered_down)
    else $error("power down not reported");
  a_pd_drv_off:
    assert property (pd_held |=> &cable_pair_a_oen && &cable_pair_b_oen)
    else $error("pair driven in power down");
  a_pd_clk_low:
    assert property (pd_held |=> !link_side_clock_out)
    else $error("clock runs in power down");
  a_cna_nobias:
    assert property ((pair_b_bias_seen == '0) [*4] |=> cable_inactive_flag)
    else $error("flag low, no bias");
  a_cna_bias:
    assert property (pair_b_bias_seen[0] [*4] |=> !cable_inactive_flag)
    else $error("flag high, bias");
  a_port1_off:
    assert property (one_port |=> !cable_bias_output[NPORT-1]
      && cable_pair_a_oen[NPORT-1] && cable_pair_b_oen[NPORT-1])
    else $error("port 1 active");
  a_linkon_half:
    assert property ($rose(contender_linkon_pin_out)
      && !contender_linkon_pin_oen |=>
      (contender_linkon_pin_out || contender_linkon_pin_oen) [*7])
    else $error("link-on half period short");
endmodule
bind phy_ctrl phy_ctrl_asserts #(.NPORT(NPORT)) phy_ctrl_asserts_i (
  .core_clk, .rstn, .power_down_pin, .port_count_select,
  .pair_b_bias_seen, .cable_bias_output, .cable_pair_a_oen,
  .cable_pair_b_oen, .cable_inactive_flag, .reset_pulldown,
  .core_powered_down, .link_side_clock_out,
  .contender_linkon_pin_out, .contender_linkon_pin_oen);

/* File: remote_node.sv */
/* remote_node: far cable node on port 0, bias per port from bias_on.
   assumes: 125 ns per bit; terminated idle lines settle low. */
`timescale 1ns/1ps
module remote_node
  import phy_ctrl_pkg::*;
(
  input  wire logic       send,
  input  wire logic [1:0] bias_on,
  output ds_pair_t  [1:0] cable_pair_in = '0,
  output logic      [1:0] pair_b_bias_seen,
  output logic      [1:0] cable_connected,
  output logic      [1:0] cable_rx_active = '0
);
  localparam logic [7:0] FRAME = 8'hb4; // runs and changes mixed
  assign pair_b_bias_seen = bias_on;
  assign cable_connected  = 2'h3;
  // ==========================================================
  // data on pair a sense, strobe on pair b sense
  always @(posedge send) begin
    logic prev;
    prev = 1'b0;
    cable_rx_active[0] = 1'b1;
    for (int b = 0; b < 8; b++) begin
      // strobe flips when data repeats
      if (FRAME[b] == prev)
        cable_pair_in[0].strobe = ~cable_pair_in[0].strobe;
      cable_pair_in[0].data = FRAME[b];
      prev = FRAME[b];
      #125;
    end
    cable_pair_in[0]   = '0;
    cable_rx_active[0] = 1'b0;
  end
endmodule

/* File: tb_top.sv */
/* tb_top: register, power, link and cable checks of phy_ctrl.
   assumes: package, partner and checker compiled first. */
`timescale 1ns/1ps
module tb_top
  import phy_ctrl_pkg::*;
;
  logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, send = 0;
  logic link_tx_valid = 0, link_request = 0, link_power_status = 1;
  logic wake_event = 0, bus_reset = 0, power_down_pin = 0;
  logic port_count_select = 1, isolation_sel_n = 1;
  logic bridge_default_pin = 1, contender_linkon_pin_in = 1;
  logic [2:0]  power_class_pins = 3'h5;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
  logic [7:0]  link_tx_data = 8'h0, link_rx_data;
  logic [1:0]  link_tx_speed = 2'h0, bias_on = 2'h0;
  logic [1:0]  pair_a_cm_fast = 2'h0, pair_a_cm_mid = 2'h0;
  logic [1:0]  cable_pair_a_oen, cable_pair_b_oen, cable_bias_output;
  logic [1:0]  pair_b_bias_seen, cable_connected, cable_rx_active;
  logic link_tx_ready, link_rx_valid, link_side_clock_out;
  logic contender_linkon_pin_out, contender_linkon_pin_oen;
  logic reset_pulldown, cable_inactive_flag, core_powered_down;
  ds_pair_t [1:0] cable_pair_in, cable_pair_out;
  int n_errors = 0, checks_done = 0, n_rx = 0, i, n;
  phy_ctrl phy_ctrl_i (.core_clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .link_tx_data, .link_tx_valid,
    .link_tx_speed, .link_request, .link_tx_ready, .link_rx_data,
    .link_rx_valid, .link_side_clock_out, .link_power_status,
    .isolation_sel_n, .wake_event, .bus_reset, .power_down_pin,
    .port_count_select, .bridge_default_pin, .power_class_pins,
    .contender_linkon_pin_in, .contender_linkon_pin_out,
    .contender_linkon_pin_oen, .reset_pulldown, .cable_inactive_flag,
    .core_powered_down, .cable_pair_in, .cable_pair_out,
    .cable_pair_a_oen, .cable_pair_b_oen, .cable_connected,
    .cable_rx_active, .pair_a_cm_fast, .pair_a_cm_mid,
    .pair_b_bias_seen, .cable_bias_output);
  remote_node remote_node_i (.send, .bias_on, .cable_pair_in,
    .pair_b_bias_seen, .cable_connected, .cable_rx_active);
  // ==========================================================
  // clock, hang guard and shared tasks
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (link_rx_valid === 1'b1) n_rx++;
  initial begin
    #100us;
    n_errors++;
    final_report;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data: cycle after strobe
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task highs(); // clock highs in 16
    n = 0;
    repeat (16) begin
      cyc(1);
      n += int'(link_side_clock_out === 1'b1);
    end
  endtask
  task final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(6);
    rd(SELFID_ADDR); chk(rdv, 32'h000c_0d00);
    rd(4'hc); chk(rdv, 32'h0);
    wr(CTRL_ADDR, 32'h100); rd(SELFID_ADDR); chk(rdv, 32'h0004_0d00);
    chk(32'(cable_inactive_flag), 32'h1);
    bias_on <= 2'h1; cyc(6); chk(32'(cable_inactive_flag), 32'h0);
    wr(CTRL_ADDR, 32'h102); cyc(3); chk(32'(cable_bias_output), 32'h2);
    port_count_select <= 1'b0; wr(CTRL_ADDR, 32'h100); cyc(6);
    chk(32'(cable_bias_output), 32'h1);
    port_count_select <= 1'b1; wr(CTRL_ADDR, 32'h118); cyc(6);
    rd(STATUS_ADDR); chk(32'({core_powered_down, rdv[6]}), 32'h3);
    wr(CTRL_ADDR, 32'h100);
    power_down_pin <= 1'b1; cyc(6);
    chk(32'({&cable_pair_a_oen, &cable_pair_b_oen, link_side_clock_out,
      cable_bias_output, reset_pulldown, core_powered_down,
      cable_inactive_flag}), 32'hc6);
    power_down_pin <= 1'b0; cyc(6);
    // link bit clear: link inactive
    wake_event <= 1'b1; cyc(4); wake_event <= 1'b0; cyc(40);
    chk(32'(contender_linkon_pin_oen), 32'h0);
    bus_reset <= 1'b1; cyc(1); bus_reset <= 1'b0; cyc(4);
    chk(32'(contender_linkon_pin_oen), 32'h1);
    wr(CTRL_ADDR, 32'h101); cyc(4);
    rd(STATUS_ADDR); chk(32'(rdv[5:3]), 32'h4);
    link_power_status <= 1'b0; cyc(300);
    rd(STATUS_ADDR); chk(32'(rdv[5:3]), 32'h1);
    highs(); chk(32'(n), 32'd8);
    cyc(2400); rd(STATUS_ADDR); chk(32'(rdv[4:3]), 32'h3);
    highs(); chk(32'(n), 32'd0);
    link_power_status <= 1'b1; cyc(5);
    rd(STATUS_ADDR); chk(32'(rdv[5:3]), 32'h4);
    bias_on <= 2'h3; send <= 1'b1; cyc(40);
    chk(32'({cable_pair_a_oen, cable_pair_b_oen}), 32'h5);
    cyc(80); send <= 1'b0; chk(32'(n_rx != 0), 32'h1);
    link_tx_data <= 8'h3c; link_tx_valid <= 1'b1; link_request <= 1'b1;
    for (i = 0; i < 40 && link_tx_ready !== 1'b0; i++) cyc(1);
    link_tx_valid <= 1'b0; link_request <= 1'b0; cyc(2);
    chk(32'({i < 40, cable_pair_a_oen[0], cable_pair_b_oen[0]}), 32'h4);
    final_report;
  end
endmodule
